// ### rtl/fepc_ctrl.sv
`include "fepc_map.svh"
module fepc_ctrl (
   input wire logic clock, // system clock
   input wire logic srst, // synchronous reset
   input wire logic prog_mode, // programming mode active
   input wire fepc_pkg::fepc_sfr_req_t sfr, // sfr access
   output logic [7:0] rdata, // read data
   output logic rd_hit, // this block answers the read
   output logic exit_req, // leave programming mode pulse
   output fepc_pkg::fepc_mem_cmd_t cmd, // command to the memory
   input wire logic verify_end, // auto-verify finished pulse
   input wire logic verify_ok, // auto-verify result
   input wire logic [23:0] checksum // checksum from the memory
);
   logic [7:0] mode_q, ctrl_q, stat_q, time_q, data_q;
   logic [23:0] adr_q;
   logic [6:0] pre_q;
   logic [9:0] tmr_q;
   fepc_pkg::fepc_state_t st_q;
   logic acc_wr, busy, do_write, do_read, ctl_reset, timer_hit, opmode;
   logic start_pe, start_vf, go_pe_q, go_vf_q;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      hit = (a == o);
   endfunction : hit

   // a launch is taken from idle, or together with a controller reset
   function automatic logic may_start(input fepc_pkg::fepc_state_t s,
      input logic r);
      may_start = (s == fepc_pkg::FEPC_IDLE) || r;
   endfunction : may_start

   assign acc_wr = sfr.wr && prog_mode;
   assign busy = (st_q != fepc_pkg::FEPC_IDLE);
   assign opmode = mode_q[`FEPC_MB_PGM] || mode_q[`FEPC_MB_ERASE];
   assign do_write = acc_wr && hit(sfr.addr, `FEPC_OFS_CTRL) &&
      sfr.wdata[`FEPC_CB_WRITE];
   assign do_read = acc_wr && hit(sfr.addr, `FEPC_OFS_CTRL) &&
      sfr.wdata[`FEPC_CB_READ];
   // controller reset
   // acts on the write itself, so the usual launch code with the reset
   // bit set restarts the sequencer instead of killing the new operation
   assign ctl_reset = acc_wr && hit(sfr.addr, `FEPC_OFS_CTRL) &&
      sfr.wdata[`FEPC_CB_CRST];
   // accepted launches
   // launches while busy are dropped unless the controller reset bit is set; software polls the done flag first
   assign start_pe = do_write && mode_q[`FEPC_MB_GATE] && opmode &&
      may_start(st_q, ctl_reset);
   assign start_vf = do_read && mode_q[`FEPC_MB_GATE] &&
      mode_q[`FEPC_MB_VFY] && opmode && may_start(st_q, ctl_reset) &&
      !start_pe;
   assign timer_hit = (tmr_q == {2'b00, time_q});

   // mode register
   // reset values
   always_ff @(posedge clock) begin
      if (srst) begin
         mode_q <= `FEPC_RST_MODE;
      end else if (acc_wr && hit(sfr.addr, `FEPC_OFS_MODE)) begin
         mode_q <= sfr.wdata;
      end
   end

   // control register; strobes live exactly one clock
   // strobes read zero
   always_ff @(posedge clock) begin
      if (srst) begin
         ctrl_q <= `FEPC_RST_CTRL;
      end else if (acc_wr && hit(sfr.addr, `FEPC_OFS_CTRL)) begin
         ctrl_q <= sfr.wdata;
      end else begin
         // keep bulk enables, drop strobes; idle buffer reset reads one
         ctrl_q <= {ctrl_q[7:6], 5'h00, 1'b1};
      end
   end

   // duration limit, data and address registers
   always_ff @(posedge clock) begin
      if (srst) begin
         time_q <= `FEPC_RST_ZERO;
         data_q <= `FEPC_RST_ZERO;
         adr_q <= 24'h000000;
      end else if (acc_wr) begin
         if (hit(sfr.addr, `FEPC_OFS_TIME)) time_q <= sfr.wdata;
         if (hit(sfr.addr, `FEPC_OFS_DATA)) data_q <= sfr.wdata;
         if (hit(sfr.addr, `FEPC_OFS_ADRL)) adr_q[7:0] <= sfr.wdata;
         if (hit(sfr.addr, `FEPC_OFS_ADRM)) adr_q[15:8] <= sfr.wdata;
         if (hit(sfr.addr, `FEPC_OFS_ADRH)) adr_q[23:16] <= sfr.wdata;
      end
   end

   // operation sequencer; launches ignored while ungated, or while busy without the reset bit
   // gate bit
   always_ff @(posedge clock) begin
      if (srst) begin
         st_q <= fepc_pkg::FEPC_IDLE;
      end else if (start_pe) begin
         st_q <= fepc_pkg::FEPC_TIMED;
      end else if (start_vf) begin
         st_q <= fepc_pkg::FEPC_VERIFY;
      end else if (ctl_reset) begin
         st_q <= fepc_pkg::FEPC_IDLE;
      end else begin
         unique case (st_q)
            fepc_pkg::FEPC_IDLE: begin
               st_q <= fepc_pkg::FEPC_IDLE;
            end
            fepc_pkg::FEPC_TIMED: begin
               if (timer_hit && pre_q == `FEPC_PRESCALE)
                  st_q <= fepc_pkg::FEPC_IDLE;
            end
            fepc_pkg::FEPC_VERIFY: begin
               if (verify_end) st_q <= fepc_pkg::FEPC_IDLE;
            end
            default: st_q <= fepc_pkg::FEPC_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (srst || start_pe || st_q != fepc_pkg::FEPC_TIMED) begin
         pre_q <= 7'h00;
         tmr_q <= 10'h000;
      end else begin
         pre_q <= pre_q + 7'h01;
         if (pre_q == `FEPC_PRESCALE && !timer_hit) tmr_q <= tmr_q + 10'h001;
      end
   end

   // launch pulses toward the memory, one clock after the accepted write
   // go pulses
   always_ff @(posedge clock) begin
      if (srst) begin
         go_pe_q <= 1'b0;
         go_vf_q <= 1'b0;
      end else begin
         go_pe_q <= start_pe;
         go_vf_q <= start_vf;
      end
   end

   // status: done flag follows the sequencer, verify result latched
   // done flag
   always_ff @(posedge clock) begin
      if (srst) begin
         stat_q <= `FEPC_RST_STAT;
      end else begin
         stat_q[`FEPC_SB_DONE] <= !busy || (st_q == fepc_pkg::FEPC_TIMED
            && timer_hit && pre_q == `FEPC_PRESCALE) ||
            (st_q == fepc_pkg::FEPC_VERIFY && verify_end);
         if (st_q == fepc_pkg::FEPC_VERIFY && verify_end)
            stat_q[`FEPC_SB_VGOOD] <= verify_ok;
         else if (acc_wr && hit(sfr.addr, `FEPC_OFS_STAT))
            stat_q[`FEPC_SB_VGOOD] <= sfr.wdata[`FEPC_SB_VGOOD];
         stat_q[5:0] <= 6'h00;
      end
   end

   // read mux; address registers read back the checksum
   // reads gated
   always_comb begin
      rd_hit = sfr.rd && prog_mode;
      unique case (sfr.addr)
         `FEPC_OFS_MODE: rdata = mode_q;
         `FEPC_OFS_CTRL: rdata = ctrl_q;
         `FEPC_OFS_STAT: rdata = stat_q;
         `FEPC_OFS_TIME: rdata = time_q;
         `FEPC_OFS_ADRL: rdata = checksum[7:0];
         `FEPC_OFS_ADRM: rdata = checksum[15:8];
         `FEPC_OFS_ADRH: rdata = checksum[23:16];
         `FEPC_OFS_DATA: rdata = data_q;
         default: begin
            rdata = 8'h00;
            rd_hit = 1'b0;
         end
      endcase
   end

   assign exit_req = ctrl_q[`FEPC_CB_EXITH] && ctrl_q[`FEPC_CB_EXITL];

   // command outputs
   always_comb begin
      cmd.main_sel = mode_q[`FEPC_MB_MAIN];
      cmd.data_sel = mode_q[`FEPC_MB_DATA];
      cmd.otp_sel = mode_q[`FEPC_MB_OTP];
      cmd.pbuf_sel = mode_q[`FEPC_MB_PBUF];
      cmd.bulk_main = ctrl_q[`FEPC_CB_BULKM];
      cmd.bulk_data = ctrl_q[`FEPC_CB_BULKD];
      cmd.buf_clear = !ctrl_q[`FEPC_CB_BRST] && !mode_q[`FEPC_MB_PBUF];
      cmd.sum_clear = !ctrl_q[`FEPC_CB_BRST] && mode_q[`FEPC_MB_PBUF];
      cmd.addr = opmode ? adr_q : 24'h000000;
      // program or erase by mode bit
      cmd.prog_go = go_pe_q && mode_q[`FEPC_MB_PGM] &&
         !mode_q[`FEPC_MB_VFY];
      cmd.erase_go = go_pe_q && mode_q[`FEPC_MB_ERASE] &&
         !mode_q[`FEPC_MB_VFY];
      cmd.verify_go = go_vf_q;
   end


   strobe_clear_a: assert property (
      @(posedge clock) disable iff (srst)
      $rose(ctrl_q[`FEPC_CB_WRITE]) |=> !ctrl_q[`FEPC_CB_WRITE] ||
      $past(do_write)) else $error("write strobe stuck");
   done_low_a: assert property (
      @(posedge clock) disable iff (srst)
      (st_q == fepc_pkg::FEPC_IDLE && $past(st_q) == fepc_pkg::FEPC_IDLE
      ##1 st_q == fepc_pkg::FEPC_TIMED) |=> !stat_q[`FEPC_SB_DONE])
      else $error("done flag not low");
   exit_pulse_a: assert property (
      @(posedge clock) disable iff (srst)
      exit_req |-> $past(acc_wr) && $past(sfr.wdata[5:4]) == 2'b11)
      else $error("exit without code 11");
   gated_write_a: assert property (
      @(posedge clock) disable iff (srst)
      !$past(prog_mode) |-> $stable(mode_q)) else $error("write outside mode");
   timer_bound_a: assert property (
      @(posedge clock) disable iff (srst)
      tmr_q <= {2'b00, time_q} || !$stable(time_q))
      else $error("timer past limit");
   buf_clear_a: assert property (
      @(posedge clock) disable iff (srst)
      !(cmd.buf_clear && cmd.sum_clear)) else $error("both clears");

   launch_timed_a: assert property (
      @(posedge clock) disable iff (srst)
      (cmd.prog_go || cmd.erase_go) |-> st_q == fepc_pkg::FEPC_TIMED)
      else $error("program pulse without timed run");

   verify_state_a: assert property (
      @(posedge clock) disable iff (srst)
      cmd.verify_go |-> st_q == fepc_pkg::FEPC_VERIFY)
      else $error("verify pulse without verify run");

   done_busy_a: assert property (
      @(posedge clock) disable iff (srst)
      st_q != fepc_pkg::FEPC_IDLE && $past(st_q) != fepc_pkg::FEPC_IDLE &&
      !$past(start_pe || start_vf) |-> !stat_q[`FEPC_SB_DONE])
      else $error("done flag high while busy");

   gate_hold_a: assert property (
      @(posedge clock) disable iff (srst)
      !mode_q[`FEPC_MB_GATE] && st_q == fepc_pkg::FEPC_IDLE |=>
      st_q == fepc_pkg::FEPC_IDLE) else $error("launch while gate is off");

   ctl_reset_a: assert property (
      @(posedge clock) disable iff (srst)
      ctl_reset && !start_pe && !start_vf |=> st_q == fepc_pkg::FEPC_IDLE)
      else $error("controller reset ignored");

   reset_values_a: assert property (
      @(posedge clock) $past(srst) |-> mode_q == `FEPC_RST_MODE &&
      ctrl_q == `FEPC_RST_CTRL && stat_q == `FEPC_RST_STAT &&
      time_q == `FEPC_RST_ZERO) else $error("register not at reset value");

   timer_clear_a: assert property (
      @(posedge clock) disable iff (srst)
      $past(start_pe) |-> tmr_q == 10'h000 && pre_q == 7'h00)
      else $error("timer not cleared at start");

   verify_flag_a: assert property (
      @(posedge clock) disable iff (srst)
      st_q == fepc_pkg::FEPC_VERIFY && verify_end |=>
      stat_q[`FEPC_SB_DONE] && stat_q[`FEPC_SB_VGOOD] == $past(verify_ok))
      else $error("verify end not reported");

   buf_strobe_a: assert property (
      @(posedge clock) disable iff (srst)
      (cmd.buf_clear || cmd.sum_clear) |-> $past(acc_wr) &&
      $past(sfr.addr) == `FEPC_OFS_CTRL && !$past(sfr.wdata[`FEPC_CB_BRST]))
      else $error("buffer clear without write");

   strobe_zero_a: assert property (
      @(posedge clock) disable iff (srst)
      !$past(srst) && !$past(acc_wr && sfr.addr == `FEPC_OFS_CTRL) |->
      ctrl_q[5:1] == 5'h00) else $error("strobe bit did not clear");
endmodule : fepc_ctrl

// ### rtl/fepc_map.svh
`ifndef FEPC_MAP_SVH
`define FEPC_MAP_SVH
// Function
// - eight registers in special-function space, reachable only in programming mode
// - mode bit 7 selects program flash, bit 6 selects data EEPROM
// - bit 5 program, bit 4 erase; with bit 1 they mean verify
// - mode bit 3 routes accesses to the page buffer
// - mode bit 2 targets the one-time-programmable area
// - mode bit 0 gates all program and erase; reads stay normal
// - control bit 7 flash bulk erase, bit 6 EEPROM bulk erase
// - exit field leaves programming mode only on code 11, self-clears
// - control bit 3 launches program or erase, self-clears after one clock
// - control bit 2 launches auto-verify, self-clears after one clock
// - control bit 1 strobe resets controller logic, self-clears
// - bit 0 low resets page buffer or checksum, per buffer bit
// - launches take their target from the address registers
// - indirect addressing only for program, erase and verify
// - reset values: zero, control 03H, status 80H
// - done flag low while operation runs, high when it ends
// - 10-bit timer at clock/128, stops at duration limit value

`define FEPC_OFS_MODE 8'hEA
`define FEPC_OFS_CTRL 8'hEB
`define FEPC_OFS_STAT 8'hEC
`define FEPC_OFS_TIME 8'hED
`define FEPC_OFS_ADRL 8'hF2
`define FEPC_OFS_ADRM 8'hF3
`define FEPC_OFS_ADRH 8'hF4
`define FEPC_OFS_DATA 8'hF5

`define FEPC_RST_MODE 8'h00
`define FEPC_RST_CTRL 8'h03
`define FEPC_RST_STAT 8'h80
`define FEPC_RST_ZERO 8'h00

`define FEPC_MB_MAIN 7
`define FEPC_MB_DATA 6
`define FEPC_MB_PGM 5
`define FEPC_MB_ERASE 4
`define FEPC_MB_PBUF 3
`define FEPC_MB_OTP 2
`define FEPC_MB_VFY 1
`define FEPC_MB_GATE 0

`define FEPC_CB_BULKM 7
`define FEPC_CB_BULKD 6
`define FEPC_CB_EXITH 5
`define FEPC_CB_EXITL 4
`define FEPC_CB_WRITE 3
`define FEPC_CB_READ 2
`define FEPC_CB_CRST 1
`define FEPC_CB_BRST 0

`define FEPC_SB_DONE 7
`define FEPC_SB_VGOOD 6

`define FEPC_PRESCALE 7'h7F
`endif

// ### rtl/fepc_pkg.sv
package fepc_pkg;
   // request from the core's special-function bus
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } fepc_sfr_req_t;
   // pulses and levels toward the memory macro
   typedef struct packed {
      logic prog_go;
      logic erase_go;
      logic verify_go;
      logic bulk_main;
      logic bulk_data;
      logic main_sel;
      logic data_sel;
      logic otp_sel;
      logic pbuf_sel;
      logic buf_clear;
      logic sum_clear;
      logic [23:0] addr;
   } fepc_mem_cmd_t;
   typedef enum logic [2:0] {
      FEPC_IDLE = 3'b001,
      FEPC_TIMED = 3'b010,
      FEPC_VERIFY = 3'b100
   } fepc_state_t;
endpackage : fepc_pkg

// ### test/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic prog_mode = 1'b1;
   fepc_pkg::fepc_sfr_req_t sfr = '0;
   logic verify_end = 1'b0;
   logic verify_ok = 1'b0;
   logic [23:0] checksum = 24'h123456;
   logic [7:0] rdata;
   logic rd_hit;
   logic exit_req;
   logic hit_seen;
   logic [7:0] v;
   fepc_pkg::fepc_mem_cmd_t cmd;
   int miscompares = 0;
   int total_checks = 0;
   int cycles = 0;

   // free-running system clock
   always #10 clock = ~clock;

   fepc_ctrl i_fepc_ctrl (.clock(clock), .srst(srst), .prog_mode(prog_mode),
      .sfr(sfr), .rdata(rdata), .rd_hit(rd_hit), .exit_req(exit_req),
      .cmd(cmd), .verify_end(verify_end), .verify_ok(verify_ok),
      .checksum(checksum));

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : give_verdict

   // hang guard, well above the few hundred cycles the run needs
   always @(posedge clock) begin
      cycles++;
      if (cycles == 8000) begin
         miscompares++;
         give_verdict();
      end
   end

   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp8

   // one-cycle write; returns in the cycle where strobes show
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      #1;
      sfr = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clock);
      #1;
      sfr = '0;
   endtask : wr

   // read data is combinational, sampled mid-cycle
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      #1;
      sfr = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      #5;
      d = rdata;
      hit_seen = rd_hit;
      @(posedge clock);
      #1;
      sfr = '0;
   endtask : rd

   // poll before next launch
   // polls done flag; each poll costs two cycles
   task automatic wait_done(output int n);
      n = 0;
      v = 8'h00;
      while (v[7] !== 1'b1 && n < 3000) begin
         rd(8'hEC, v);
         n += 2;
      end
   endtask : wait_done

   task automatic t_reset;
      int i;
      logic [7:0] adr [5] = '{8'hEA, 8'hEB, 8'hEC, 8'hED, 8'hF5};
      logic [7:0] exp [5] = '{8'h00, 8'h01, 8'h80, 8'h00, 8'h00};
      for (i = 0; i < 5; i++) begin
         rd(adr[i], v);
         cmp8((adr[i] == 8'hEC) ? (v & 8'h80) : v, exp[i]);
      end
      rd(8'h00, v);
      cmp8({7'h00, hit_seen}, 8'h00);
      prog_mode = 1'b0;
      wr(8'hEA, 8'hA1);
      rd(8'hEA, v);
      cmp8({7'h00, hit_seen}, 8'h00);
      prog_mode = 1'b1;
      rd(8'hEA, v);
      cmp8(v, 8'h00);
   endtask : t_reset

   // limit 1 gives (1+1)*128 clocks of busy time
   task automatic t_program;
      int n;
      wr(8'hED, 8'h01);
      wr(8'hF2, 8'h34);
      wr(8'hF3, 8'h12);
      wr(8'hF4, 8'h01);
      wr(8'hEA, 8'hA1);
      wr(8'hEB, 8'h0B);
      cmp8({cmd.prog_go, cmd.erase_go, cmd.main_sel}, 8'h05);
      cmp8(cmd.addr[23:16], 8'h01);
      cmp8(cmd.addr[15:0] == 16'h1234, 8'h01);
      wait_done(n);
      cmp8(n >= 252 && n <= 262, 8'h01);
      rd(8'hEB, v);
      cmp8(v, 8'h01);
   endtask : t_program

   task automatic t_gate_erase;
      int n;
      wr(8'hED, 8'h00);
      wr(8'hEA, 8'hA0);
      wr(8'hEB, 8'h0B);
      cmp8(cmd.prog_go, 8'h00);
      wr(8'hEA, 8'h91);
      wr(8'hEB, 8'h0B);
      cmp8({cmd.erase_go, cmd.prog_go}, 8'h02);
      rd(8'hEC, v);
      cmp8(v[7], 8'h00);
      wait_done(n);
      cmp8(n >= 124 && n <= 134, 8'h01);
      wr(8'hEB, 8'h09);
      rd(8'hEC, v);
      cmp8(v[7], 8'h00);
      wr(8'hEB, 8'h03);
      rd(8'hEC, v);
      cmp8(v[7], 8'h01);
   endtask : t_gate_erase

   task automatic t_verify;
      wr(8'hEA, 8'hA3);
      wr(8'hEB, 8'h05);
      cmp8(cmd.verify_go, 8'h01);
      @(posedge clock);
      #1;
      verify_end = 1'b1;
      verify_ok = 1'b1;
      @(posedge clock);
      #1;
      verify_end = 1'b0;
      rd(8'hEC, v);
      cmp8(v & 8'hC0, 8'hC0);
   endtask : t_verify

   task automatic t_misc;
      int c;
      for (c = 1; c < 4; c++) begin
         wr(8'hEB, 8'h01 | (8'(c) << 4));
         cmp8(exit_req, (c == 3) ? 8'h01 : 8'h00);
      end
      wr(8'hEA, 8'h81);
      wr(8'hEB, 8'h00);
      cmp8({cmd.buf_clear, cmd.sum_clear}, 8'h02);
      wr(8'hEA, 8'h89);
      cmp8(cmd.pbuf_sel, 8'h01);
      wr(8'hEB, 8'h00);
      cmp8({cmd.buf_clear, cmd.sum_clear}, 8'h01);
      wr(8'hEB, 8'hC1);
      cmp8({cmd.bulk_main, cmd.bulk_data}, 8'h03);
      rd(8'hEB, v);
      cmp8(v, 8'hC1);
      wr(8'hEA, 8'h45);
      cmp8({cmd.main_sel, cmd.data_sel}, 8'h01);
      cmp8(cmd.otp_sel, 8'h01);
      cmp8(cmd.addr[7:0], 8'h00);
   endtask : t_misc

   // main sequence
   initial begin
      repeat (4) @(posedge clock);
      #1;
      srst = 1'b0;
      t_reset();
      t_program();
      t_gate_erase();
      t_verify();
      t_misc();
      give_verdict();
   end
endmodule : tb_top
